// file: design/temp_sensor_port.sv
/*
 * sensor end: serial response/command port, register file and conversion pacing.
 * assumes a host that makes the serial clock, idle low, and keeps its own side of the link.
 */
// Contract
// - convert continuously, serve last completed result
// - first 16 clocks after select return response
// - response goes out sign bit first, descending
// - host may end read early, no error
// - after response, 16 clocks carry a command
// - read command: bit 15, address bits 4:3
// - address held until full response completes
// - 16th response clock resets address to temperature
// - writes leave read address unchanged
// - response sourced from latched read address
// - commands and responses alternate while selected
// - after a write, temperature data follows
// - config write tag 010, upper nibble zero
// - low byte all ones means shutdown
// - resolution 9 to 12 bits plus sign
// - temp word: value, bit2 high, bits1:0 floating
// - config resets to resolution 11, tag 010, rest zero
// - other commands wake; sleep after conversion ends
`timescale 1ns/1ps
module temp_sensor_port #(
	parameter int CONV_BASE_CYCLES = temp_spi_pkg::CONV_9BIT_CYCLES
) (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	temp_spi_if.dev          L,
	input  wire logic [12:0] TEMP_SAMPLE,
	output logic      [12:0] TEMP_RESULT,
	output logic      [15:0] CONFIG_WORD,
	output logic      [12:0] LOWER_LIMIT,
	output logic      [12:0] UPPER_LIMIT,
	output logic             SHUTDOWN,
	output logic             CONV_DONE
);
	logic [2:0]               raw;
	logic [2:0]               s1_r;
	logic [2:0]               s2_r;
	logic [2:0]               s3_r;
	logic [2:0]               filt_r;
	logic [2:0]               filt_nxt;
	logic                     cs_fall;
	logic                     cs_high;
	logic                     sck_rise;
	logic                     sck_fall;
	logic                     sio_in;
	temp_spi_pkg::dev_state_t state_r;
	logic [4:0]               cnt_r;
	logic [3:0]               shifts_r;
	logic [15:0]              shift_r;
	logic                     float_r;
	logic [1:0]               ptr_r;
	logic [15:0]              cmd_w;
	logic                     cmd_last;
	logic                     is_read;
	logic                     is_shut;
	logic                     is_cfg;
	logic                     is_low;
	logic                     is_high;
	logic [15:0]              resp_word;
	logic                     resp_float;
	logic                     resp_last;
	logic [1:0]               res;
	logic [31:0]              conv_limit;
	logic [31:0]              conv_cnt_r;
	logic                     conv_end;
	logic                     sleep_req_r;
	logic [12:0]              temp_masked;

	// three-stage sync; a change counts once stages two and three agree
	assign raw      = {L.cs_n, L.sck, L.sio};
	assign filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
	assign cs_fall  = filt_r[2] & ~filt_nxt[2];
	assign cs_high  = filt_nxt[2];
	assign sck_rise = ~filt_r[1] & filt_nxt[1] & ~cs_high;
	assign sck_fall = filt_r[1] & ~filt_nxt[1] & ~cs_high;
	assign sio_in   = filt_nxt[0];

	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			s1_r   <= temp_spi_pkg::DEV_SYNC_IDLE;
			s2_r   <= temp_spi_pkg::DEV_SYNC_IDLE;
			s3_r   <= temp_spi_pkg::DEV_SYNC_IDLE;
			filt_r <= temp_spi_pkg::DEV_SYNC_IDLE;
		end
		else if (CE)
		begin
			s1_r   <= raw;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= filt_nxt;
		end
	end

	// command decode on the 16th sampled bit
	assign cmd_w    = {shift_r[14:0], sio_in};
	assign cmd_last = (state_r == temp_spi_pkg::D_CMD) && sck_rise
		&& (cnt_r == 5'(temp_spi_pkg::WORD_BITS - 1));
	assign is_shut  = cmd_w[7:0] == temp_spi_pkg::SHUTDOWN_BYTE;
	assign is_read  = cmd_w[temp_spi_pkg::CMD_READ_BIT]
		&& ((cmd_w & ~temp_spi_pkg::READ_CMD_ALLOWED) == 16'h0000);
	assign is_cfg   = !is_shut && !is_read
		&& (cmd_w[temp_spi_pkg::CFG_TOP_HI:temp_spi_pkg::CFG_TOP_LO] == 4'h0)
		&& (cmd_w[temp_spi_pkg::TAG_HI:0] == temp_spi_pkg::TAG_CFG);
	assign is_low   = !is_shut && !is_read
		&& (cmd_w[temp_spi_pkg::TAG_HI:0] == temp_spi_pkg::TAG_LOW);
	assign is_high  = !is_shut && !is_read
		&& (cmd_w[temp_spi_pkg::TAG_HI:0] == temp_spi_pkg::TAG_HIGH);

	// word selected by the latched address; temp word floats its two lowest bits
	assign resp_word = (ptr_r == temp_spi_pkg::PTR_CFG) ? CONFIG_WORD
		: (ptr_r == temp_spi_pkg::PTR_LOW) ? {LOWER_LIMIT, temp_spi_pkg::LIMIT_TAIL}
		: (ptr_r == temp_spi_pkg::PTR_HIGH) ? {UPPER_LIMIT, temp_spi_pkg::LIMIT_TAIL}
		: {TEMP_RESULT, temp_spi_pkg::TEMP_TAIL};
	assign resp_float = ptr_r == temp_spi_pkg::PTR_TEMP;
	assign resp_last  = (state_r == temp_spi_pkg::D_RESP) && sck_rise
		&& (cnt_r == 5'(temp_spi_pkg::WORD_BITS - 1));

	// drive only while a response is on the pin
	assign L.dev_sio_o   = shift_r[15];
	assign L.dev_sio_oe_n = !(((state_r == temp_spi_pkg::D_RESP)
		|| (state_r == temp_spi_pkg::D_TURN_CMD))
		&& !(float_r && (shifts_r >= 4'(temp_spi_pkg::FLOAT_FROM_SHIFT))));

	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			state_r  <= temp_spi_pkg::D_IDLE;
			cnt_r    <= 5'h00;
			shifts_r <= 4'h0;
			shift_r  <= 16'h0000;
			float_r  <= 1'b0;
		end
		else if (CE)
		begin
			if (cs_high)
				state_r <= temp_spi_pkg::D_IDLE;
			else
			begin
				unique case (state_r)
					temp_spi_pkg::D_IDLE:
						if (cs_fall)
						begin
							state_r  <= temp_spi_pkg::D_RESP;
							shift_r  <= resp_word;
							float_r  <= resp_float;
							cnt_r    <= 5'h00;
							shifts_r <= 4'h0;
						end
					temp_spi_pkg::D_RESP:
						if (resp_last)
							state_r <= temp_spi_pkg::D_TURN_CMD;
						else if (sck_rise)
							cnt_r <= cnt_r + 5'h01;
						else if (sck_fall)
						begin
							shift_r  <= {shift_r[14:0], 1'b0};
							shifts_r <= shifts_r + 4'h1;
						end
					temp_spi_pkg::D_TURN_CMD:
						if (sck_fall)
						begin
							state_r <= temp_spi_pkg::D_CMD;
							cnt_r   <= 5'h00;
						end
					temp_spi_pkg::D_CMD:
						if (cmd_last)
							state_r <= temp_spi_pkg::D_TURN_RESP;
						else if (sck_rise)
						begin
							shift_r <= cmd_w;
							cnt_r   <= cnt_r + 5'h01;
						end
					temp_spi_pkg::D_TURN_RESP:
						if (sck_fall)
						begin
							state_r  <= temp_spi_pkg::D_RESP;
							shift_r  <= resp_word;
							float_r  <= resp_float;
							cnt_r    <= 5'h00;
							shifts_r <= 4'h0;
						end
				endcase
			end
		end
	end

	// read address: set by reads, cleared by a full response, untouched by writes
	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
			ptr_r <= temp_spi_pkg::PTR_TEMP;
		else if (CE)
		begin
			if (resp_last)
				ptr_r <= temp_spi_pkg::PTR_TEMP;
			else if (cmd_last && is_read)
				ptr_r <= cmd_w[temp_spi_pkg::PTR_HI:temp_spi_pkg::PTR_LO];
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			CONFIG_WORD <= temp_spi_pkg::CFG_RESET;
			LOWER_LIMIT <= temp_spi_pkg::LOW_RESET;
			UPPER_LIMIT <= temp_spi_pkg::HIGH_RESET;
			sleep_req_r <= 1'b0;
		end
		else if (CE && cmd_last)
		begin
			sleep_req_r <= is_shut;
			if (is_cfg)
				CONFIG_WORD <= {4'h0, cmd_w[temp_spi_pkg::CFG_FIELD_HI:temp_spi_pkg::CFG_FIELD_LO],
					temp_spi_pkg::TAG_CFG};
			if (is_low)
				LOWER_LIMIT <= cmd_w[15:3];
			if (is_high)
				UPPER_LIMIT <= cmd_w[15:3];
		end
	end

	// pacing: base time doubles per extra resolution bit
	assign res         = CONFIG_WORD[temp_spi_pkg::RES_HI:temp_spi_pkg::RES_LO];
	assign conv_limit  = 32'(CONV_BASE_CYCLES) << res;
	assign conv_end    = !SHUTDOWN && (conv_cnt_r >= conv_limit - 32'h00000001);
	assign temp_masked = TEMP_SAMPLE & ~(temp_spi_pkg::RES_DROP_MASK >> res);

	// a conversion in flight always finishes before sleep; a wake restarts it cleanly
	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			conv_cnt_r  <= 32'h00000000;
			TEMP_RESULT <= temp_spi_pkg::TEMP_RESET;
			SHUTDOWN    <= 1'b0;
			CONV_DONE   <= 1'b0;
		end
		else if (CE)
		begin
			CONV_DONE <= conv_end;
			if (!sleep_req_r)
				SHUTDOWN <= 1'b0;
			if (conv_end)
			begin
				TEMP_RESULT <= temp_masked;
				conv_cnt_r  <= 32'h00000000;
				SHUTDOWN    <= sleep_req_r;
			end
			else if (!SHUTDOWN)
				conv_cnt_r <= conv_cnt_r + 32'h00000001;
		end
	end
endmodule

// file: design/temp_spi_host.sv
/*
 * host end: makes select and serial clock, reads responses and sends commands.
 * assumes the sensor end on the other side of the link interface.
 */
`timescale 1ns/1ps
module temp_spi_host #(
	parameter int HALF_CYCLES = temp_spi_pkg::SCK_HALF_CYCLES
) (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	temp_spi_if.host         L,
	input  wire logic        START,
	input  wire logic [4:0]  RESP_LEN,
	input  wire logic        CMD_EN,
	input  wire logic [15:0] CMD_WORD,
	input  wire logic        HOLD,
	output logic             BUSY,
	output logic             RESP_VALID,
	output logic      [15:0] RESP_DATA
);
	logic                      s1_r;
	logic                      s2_r;
	logic                      s3_r;
	logic                      sio_r;
	temp_spi_pkg::host_state_t state_r;
	logic [7:0]                div_r;
	logic                      tick;
	logic                      sample;
	logic [4:0]                bits_r;
	logic [4:0]                len_r;
	logic                      cmd_en_r;
	logic                      hold_r;
	logic [15:0]               out_r;
	logic                      cs_n_r;
	logic                      sck_r;
	logic                      oe_n_r;

	assign tick   = div_r == 8'(HALF_CYCLES - 1);
	// sample late in the high half so the sensor's sync delay has settled
	assign sample = sck_r && (div_r == 8'(HALF_CYCLES - 2)) && (state_r == temp_spi_pkg::H_RESP);
	assign BUSY   = (state_r != temp_spi_pkg::H_IDLE) && (state_r != temp_spi_pkg::H_HOLD);
	assign L.cs_n = cs_n_r;
	assign L.sck  = sck_r;
	assign L.host_sio_o   = out_r[15];
	assign L.host_sio_oe_n = oe_n_r;

	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			s1_r  <= 1'b1;
			s2_r  <= 1'b1;
			s3_r  <= 1'b1;
			sio_r <= 1'b1;
		end
		else if (CE)
		begin
			s1_r <= L.sio;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				sio_r <= s3_r;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RESET_N)
		begin
			state_r    <= temp_spi_pkg::H_IDLE;
			div_r      <= 8'h00;
			bits_r     <= 5'h00;
			len_r      <= 5'h10;
			cmd_en_r   <= 1'b0;
			hold_r     <= 1'b0;
			out_r      <= 16'h0000;
			cs_n_r     <= 1'b1;
			sck_r      <= 1'b0;
			oe_n_r     <= 1'b1;
			RESP_VALID <= 1'b0;
			RESP_DATA  <= 16'h0000;
		end
		else if (CE)
		begin
			RESP_VALID <= 1'b0;
			div_r      <= tick ? 8'h00 : div_r + 8'h01;
			if (sample)
				RESP_DATA <= {RESP_DATA[14:0], sio_r};
			unique case (state_r)
				temp_spi_pkg::H_IDLE, temp_spi_pkg::H_HOLD:
				begin
					div_r <= 8'h00;
					if (START)
					begin
						state_r  <= (state_r == temp_spi_pkg::H_IDLE)
							? temp_spi_pkg::H_LEAD : temp_spi_pkg::H_RESP;
						cs_n_r   <= 1'b0;
						bits_r   <= 5'h00;
						len_r    <= RESP_LEN;
						cmd_en_r <= CMD_EN;
						hold_r   <= HOLD;
						out_r    <= CMD_WORD;
					end
				end
				temp_spi_pkg::H_LEAD:
					if (tick)
						state_r <= temp_spi_pkg::H_RESP;
				temp_spi_pkg::H_RESP:
					if (tick && !sck_r)
					begin
						sck_r  <= 1'b1;
						bits_r <= bits_r + 5'h01;
					end
					else if (tick)
					begin
						sck_r <= 1'b0;
						if (bits_r == len_r)
						begin
							RESP_VALID <= 1'b1;
							bits_r     <= 5'h00;
							if ((len_r == 5'(temp_spi_pkg::WORD_BITS)) && cmd_en_r)
							begin
								state_r <= temp_spi_pkg::H_CMD;
								oe_n_r  <= 1'b0;
							end
							else
								state_r <= temp_spi_pkg::H_TAIL;
						end
					end
				temp_spi_pkg::H_CMD:
					if (tick && !sck_r)
					begin
						sck_r  <= 1'b1;
						bits_r <= bits_r + 5'h01;
					end
					else if (tick)
					begin
						sck_r <= 1'b0;
						if (bits_r == 5'(temp_spi_pkg::WORD_BITS))
						begin
							oe_n_r  <= 1'b1;
							state_r <= hold_r ? temp_spi_pkg::H_HOLD : temp_spi_pkg::H_TAIL;
						end
						else
							out_r <= {out_r[14:0], 1'b0};
					end
				temp_spi_pkg::H_TAIL:
					if (tick)
					begin
						cs_n_r  <= 1'b1;
						state_r <= temp_spi_pkg::H_IDLE;
					end
			endcase
		end
	end
endmodule

// file: design/temp_spi_if.sv
/*
 * link between the sensor end and the host end: select, serial clock and one shared data pin.
 * assumes the pin has a pull-up, so it reads high when neither end drives it.
 */
`timescale 1ns/1ps
interface temp_spi_if;
	logic cs_n;
	logic sck;
	logic dev_sio_o;
	logic dev_sio_oe_n;
	logic host_sio_o;
	logic host_sio_oe_n;
	logic sio;

	// device wins a collision; during a turnaround the pull-up pulls the pin high
	assign sio = !dev_sio_oe_n ? dev_sio_o : (!host_sio_oe_n ? host_sio_o : 1'b1);

	modport dev (input cs_n, input sck, input sio, output dev_sio_o, output dev_sio_oe_n);
	modport host (output cs_n, output sck, output host_sio_o, output host_sio_oe_n, input sio);
endinterface

// file: design/temp_spi_pkg.sv
/*
 * constants and state types shared by both ends of the temperature sensor serial port.
 * assumes a 100 MHz core clock on each end and a serial clock made by the host.
 */
package temp_spi_pkg;
	localparam int          WORD_BITS        = 16;
	localparam int          TEMP_BITS        = 13;
	localparam int          CMD_READ_BIT     = 15;
	localparam int          PTR_HI           = 4;
	localparam int          PTR_LO           = 3;
	localparam logic [1:0]  PTR_TEMP         = 2'h0;
	localparam logic [1:0]  PTR_CFG          = 2'h1;
	localparam logic [1:0]  PTR_LOW          = 2'h2;
	localparam logic [1:0]  PTR_HIGH         = 2'h3;
	localparam logic [15:0] READ_CMD_ALLOWED = 16'h8018;
	localparam int          CFG_TOP_HI       = 15;
	localparam int          CFG_TOP_LO       = 12;
	localparam int          CFG_FIELD_HI     = 11;
	localparam int          CFG_FIELD_LO     = 3;
	localparam int          RES_HI           = 9;
	localparam int          RES_LO           = 8;
	localparam int          TAG_HI           = 2;
	localparam logic [2:0]  TAG_CFG          = 3'h2;
	localparam logic [2:0]  TAG_LOW          = 3'h4;
	localparam logic [2:0]  TAG_HIGH         = 3'h6;
	localparam logic [2:0]  TEMP_TAIL        = 3'h4;
	localparam logic [2:0]  LIMIT_TAIL       = 3'h0;
	localparam logic [7:0]  SHUTDOWN_BYTE    = 8'hFF;
	localparam logic [15:0] CFG_RESET        = 16'h0302;
	localparam logic [12:0] LOW_RESET        = 13'h04B0;
	localparam logic [12:0] HIGH_RESET       = 13'h0500;
	localparam logic [12:0] TEMP_RESET       = 13'h0000;
	localparam logic [12:0] RES_DROP_MASK    = 13'h0007;
	localparam int          FLOAT_FROM_SHIFT = 14;
	localparam int          CLK_MHZ          = 100;
	localparam int          CLK_KHZ          = CLK_MHZ * 1000;
	localparam int          CONV_9BIT_MS     = 30;
	localparam int          CONV_12BIT_MAX_MS = 320;
	localparam int          CONV_9BIT_CYCLES = CONV_9BIT_MS * CLK_KHZ;
	localparam int          SCK_HALF_CYCLES  = 8;
	localparam logic [2:0]  DEV_SYNC_IDLE    = 3'h5;

	typedef enum logic [2:0] {D_IDLE, D_RESP, D_TURN_CMD, D_CMD, D_TURN_RESP} dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_RESP, H_CMD, H_HOLD, H_TAIL} host_state_t;
endpackage

// file: tb/temp_sensor_spi_cmd_port_bench.sv
/*
 * bench for both ends of the sensor link joined by one interface.
 * assumes the default host half period and a short conversion base.
 */
`timescale 1ns/1ps
module temp_sensor_spi_cmd_port_bench;
	localparam int          BASE   = 100;
	localparam int          LIMIT  = 60000;
	localparam logic [12:0] SAMPLE = 13'h1C8F;
	localparam logic [15:0] TWORD  = {SAMPLE, 3'h7};
	logic        mclk    = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce      = 1'b1;
	logic [12:0] sample  = SAMPLE;
	logic        start   = 1'b0;
	logic [4:0]  len     = 5'h10;
	logic        cmd_en  = 1'b0;
	logic [15:0] cmd     = 16'h0000;
	logic        hold    = 1'b0;
	logic        busy;
	logic        valid;
	logic [15:0] data;
	logic [12:0] temp_res;
	logic [15:0] cfg;
	logic [12:0] low;
	logic [12:0] high;
	logic        sd;
	logic        done;
	logic [15:0] got;
	int          error_cnt   = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	int          p;
	logic [15:0] row_cmd [8] = '{16'h0F7A, 16'h8008, 16'hF804, 16'h8010,
		16'h3206, 16'h8018, 16'h8000, 16'h0000};
	logic [15:0] row_exp [8] = '{TWORD, TWORD, 16'h0F7A, TWORD, 16'hF800, TWORD,
		16'h3200, TWORD};

	temp_spi_if link ();
	temp_sensor_port #(.CONV_BASE_CYCLES(BASE)) temp_sensor_port_inst (.MCLK(mclk),
		.RESET_N(reset_n), .CE(ce), .L(link), .TEMP_SAMPLE(sample), .TEMP_RESULT(temp_res),
		.CONFIG_WORD(cfg), .LOWER_LIMIT(low), .UPPER_LIMIT(high), .SHUTDOWN(sd),
		.CONV_DONE(done));
	temp_spi_host temp_spi_host_inst (.MCLK(mclk), .RESET_N(reset_n), .CE(ce), .L(link),
		.START(start), .RESP_LEN(len), .CMD_EN(cmd_en), .CMD_WORD(cmd), .HOLD(hold),
		.BUSY(busy), .RESP_VALID(valid), .RESP_DATA(data));
	temp_sensor_spi_cmd_port_checker temp_sensor_spi_cmd_port_checker_inst (.MCLK(mclk),
		.RESET_N(reset_n), .cs_n(link.cs_n), .sck(link.sck), .dev_sio_o(link.dev_sio_o),
		.dev_sio_oe_n(link.dev_sio_oe_n), .host_sio_o(link.host_sio_o),
		.host_sio_oe_n(link.host_sio_oe_n), .sio(link.sio));

	always #5 mclk = ~mclk;

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			error_cnt++;
			conclude;
		end
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one selection step; a gap after deselect lets the sensor's input sync settle
	task automatic xfer(input logic [4:0] n, input logic [15:0] c, input logic en,
		input logic h);
		@(negedge mclk);
		len = n;
		cmd = c;
		cmd_en = en;
		hold = h;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		while (valid !== 1'b1)
			@(negedge mclk);
		got = data;
		while (busy !== 1'b0)
			@(negedge mclk);
		if (!h)
			repeat (10) @(negedge mclk);
	endtask

	task automatic conv_gap(output int g);
		g = 0;
		while (done !== 1'b1)
			@(negedge mclk);
		@(negedge mclk);
		while (done !== 1'b1)
		begin
			@(negedge mclk);
			g++;
		end
	endtask

	initial
	begin
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		while (done !== 1'b1)
			@(negedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			xfer(5'h10, row_cmd[i], i < 7, i < 7);
			chk("row response", got, row_exp[i]);
			$display("row %0d done", i);
		end
		chk("config", cfg, 16'h0F7A);
		chk("lower limit", 16'(low), 16'h1F00);
		chk("upper limit", 16'(high), 16'h0640);
		xfer(5'h10, 16'h8008, 1'b1, 1'b0);
		chk("after read", got, TWORD);
		xfer(5'h08, 16'h0000, 1'b0, 1'b0);
		chk("partial", 16'(got[7:0]), 16'h000F);
		xfer(5'h10, 16'h0000, 1'b0, 1'b0);
		chk("kept address", got, 16'h0F7A);
		xfer(5'h10, 16'h0000, 1'b0, 1'b0);
		chk("address cleared", got, TWORD);
		$display("partial read done");
		xfer(5'h10, 16'hA5FF, 1'b1, 1'b0);
		chk("config kept", cfg, 16'h0F7A);
		// sleep may already have begun during the gap, so wait on the flag with a bound
		for (int k = 0; k < 2000 && sd !== 1'b1; k++)
			@(negedge mclk);
		chk("asleep", 16'(sd), 16'h0001);
		xfer(5'h10, 16'h8000, 1'b1, 1'b0);
		chk("awake", 16'(sd), 16'h0000);
		$display("shutdown done");
		// coarser settings clear the unused low bits of the result
		for (int r = 0; r < 4; r++)
		begin
			xfer(5'h10, 16'h0002 | (16'(r) << 8), 1'b1, 1'b0);
			conv_gap(p);
			conv_gap(p);
			chk("conversion gap", 16'(p), 16'((BASE << r) - 1));
			chk("result", 16'(temp_res), 16'(SAMPLE & ~13'((1 << (3 - r)) - 1)));
		end
		$display("resolution done");
		// a low enable stretches the conversion by exactly the frozen cycles
		while (done !== 1'b1)
			@(negedge mclk);
		@(negedge mclk);
		ce = 1'b0;
		repeat (50) @(negedge mclk);
		ce = 1'b1;
		p = 0;
		while (done !== 1'b1)
		begin
			@(negedge mclk);
			p++;
		end
		chk("frozen gap", 16'(p), 16'((BASE << 3) - 1));
		$display("freeze done");
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		chk("config reset", cfg, 16'h0302);
		chk("asleep reset", 16'(sd), 16'h0000);
		xfer(5'h10, 16'h0000, 1'b0, 1'b0);
		chk("zero reading", got, 16'h0007);
		$display("reset done");
		conclude;
	end
endmodule

// file: tb/temp_sensor_spi_cmd_port_checker.sv
/*
 * checker for the sensor link, watching only the interface wires.
 * assumes the host half period of 8 core clocks and both ends on MCLK.
 */
`timescale 1ns/1ps
module temp_sensor_spi_cmd_port_checker (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic dev_sio_o,
	input wire logic dev_sio_oe_n,
	input wire logic host_sio_o,
	input wire logic host_sio_oe_n,
	input wire logic sio
);
	logic       sck_r;
	logic [4:0] rise_r;
	wire        high_w = sck && sck_r && !cs_n;
	// the 32nd rise wraps to zero and is left unchecked
	wire        cmd_w  = rise_r > 5'h10;
	// last two response bits may float in a temperature word
	wire        resp_w = rise_r != 5'h00 && rise_r < 5'h0F;
	always_ff @(posedge MCLK)
	begin
		sck_r  <= sck;
		rise_r <= (!RESET_N || cs_n) ? 5'h00 : rise_r + 5'(sck && !sck_r);
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	AST_SELECT_DRIVE: assert property ($fell(cs_n) |-> ##[1:8] !dev_sio_oe_n)
		else $error("sensor silent after select");
	AST_DESELECT_RELEASE: assert property (cs_n [*8] |-> dev_sio_oe_n)
		else $error("sensor drives while deselected");
	AST_HOST_IDLE: assert property (cs_n |-> host_sio_oe_n && !sck)
		else $error("host active while deselected");
	AST_RESP_DRIVE: assert property (high_w && resp_w |-> !dev_sio_oe_n)
		else $error("sensor not driving a response bit");
	AST_CMD_RELEASE: assert property (high_w && cmd_w |-> dev_sio_oe_n)
		else $error("sensor drives during a command");
	AST_DEV_SHIFT: assert property (high_w && !dev_sio_oe_n && !$past(dev_sio_oe_n)
		|-> $stable(dev_sio_o))
		else $error("sensor bit moved while clock high");
	AST_HOST_SHIFT: assert property (high_w && !host_sio_oe_n && !$past(host_sio_oe_n)
		|-> $stable(host_sio_o))
		else $error("host bit moved while clock high");
	AST_HALF_PERIOD: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("serial clock high phase wrong");
	AST_PIN_RESOLVE: assert property (!dev_sio_oe_n |-> sio == dev_sio_o)
		else $error("pin does not follow sensor");
	AST_PIN_PULLUP: assert property (dev_sio_oe_n && host_sio_oe_n |-> sio)
		else $error("released pin not high");
endmodule
